// ### csf_regs.vh
// Notes on behaviour
// - Status register is a legal instruction destination
// - Flag-updating ops override written arithmetic flags
// - Writes to expiry and sleep flags ignored
// - Clearing status gives 000u u1uu
// - Bit clear/set and move keep arithmetic flags
// - Bit 7 shows pin-change wake reset cause
// - Bit 5 selects program page 1 or 0
// - Expiry flag set by power-up, kick, sleep
// - Sleep flag set by power-up, kick; sleep clears
// - Z set when clear, add, subtract or logic result is zero
// - Add sets nibble flag on low-nibble carry
// - Subtract sets nibble flag when no borrow
// - C is carry, or inverted borrow after subtract
// - Rotates load C from LSb or MSb
`ifndef CSF_REGS_VH
`define CSF_REGS_VH

// Register indices; byte address is four times the index
`define CSF_IDX_STATUS 6'h03
`define CSF_IDX_IRQ_STAT 6'h04
`define CSF_IDX_IRQ_EN 6'h05
`define CSF_IDX_IRQ_CLR 6'h06

// Status field positions
`define CSF_B_WAKE 7
`define CSF_B_RSVD 6
`define CSF_B_PAGE 5
`define CSF_B_WDX 4
`define CSF_B_SLP 3
`define CSF_B_Z 2
`define CSF_B_NIB 1
`define CSF_B_C 0

// Status value after power-on (arithmetic flags unknown, taken as 0)
`define CSF_STATUS_RST 8'h18

// Instruction codes from the datapath
`define CSF_OP_NOP 4'h0
`define CSF_OP_MOVE 4'h1
`define CSF_OP_BCLR 4'h2
`define CSF_OP_BSET 4'h3
`define CSF_OP_CLR 4'h4
`define CSF_OP_ADD 4'h5
`define CSF_OP_SUB 4'h6
`define CSF_OP_ROR 4'h7
`define CSF_OP_ROL 4'h8
`define CSF_OP_LOGIC 4'h9
`define CSF_OP_KICK 4'ha
`define CSF_OP_SLEEP 4'hb

// Interrupt event bit positions
`define CSF_EV_TIMEOUT 0
`define CSF_EV_SLEEP 1
`define CSF_EV_KICK 2
`define CSF_EV_WAKE 3
`define CSF_EV_OVERRIDE 4
`define CSF_EV_W 5

`endif

// ### csf_flag_alu.v
`include "csf_regs.vh"

// Computes an instruction's result and its arithmetic flags
module csf_flag_alu (
    // Operation and operands
    input wire [3:0] op,
    input wire [7:0] f_val,
    input wire [7:0] w_val,
    input wire [2:0] bit_sel,
    input wire [7:0] logic_res,
    input wire c_in,
    // Result and flags
    output reg [7:0] res,
    output reg z_out,
    output reg dc_out,
    output reg c_out,
    output reg z_upd,
    output reg dcc_upd,
    output reg c_only_upd
);
    wire [8:0] add_sum; // Full add with carry out
    wire [4:0] add_nib; // Low nibble add
    wire [8:0] sub_sum; // f + ~w + 1, carry is inverted borrow
    wire [4:0] sub_nib; // Low nibble subtract
    wire [7:0] bit_mask; // One-hot bit select

    assign add_sum = {1'b0, f_val} + {1'b0, w_val};
    assign add_nib = {1'b0, f_val[3:0]} + {1'b0, w_val[3:0]};
    assign sub_sum = {1'b0, f_val} + {1'b0, ~w_val} + 9'h001;
    assign sub_nib = {1'b0, f_val[3:0]} + {1'b0, ~w_val[3:0]} + 5'h01;
    assign bit_mask = 8'h01 << bit_sel;

    // Result and flag selection per operation
    always @* begin
        res = f_val;
        z_out = 1'b0;
        dc_out = 1'b0;
        c_out = c_in;
        z_upd = 1'b0;
        dcc_upd = 1'b0;
        c_only_upd = 1'b0;
        case (op)
            `CSF_OP_MOVE: res = w_val;
            `CSF_OP_BCLR: res = f_val & ~bit_mask;
            `CSF_OP_BSET: res = f_val | bit_mask;
            `CSF_OP_CLR: begin
                res = 8'h00;
                z_out = 1'b1;
                z_upd = 1'b1;
            end
            `CSF_OP_ADD: begin
                res = add_sum[7:0];
                z_out = (add_sum[7:0] == 8'h00);
                dc_out = add_nib[4];
                c_out = add_sum[8];
                z_upd = 1'b1;
                dcc_upd = 1'b1;
            end
            `CSF_OP_SUB: begin
                res = sub_sum[7:0];
                z_out = (sub_sum[7:0] == 8'h00);
                dc_out = sub_nib[4];
                c_out = sub_sum[8];
                z_upd = 1'b1;
                dcc_upd = 1'b1;
            end
            `CSF_OP_ROR: begin
                res = {c_in, f_val[7:1]};
                c_out = f_val[0];
                c_only_upd = 1'b1;
            end
            `CSF_OP_ROL: begin
                res = {f_val[6:0], c_in};
                c_out = f_val[7];
                c_only_upd = 1'b1;
            end
            `CSF_OP_LOGIC: begin
                res = logic_res;
                z_out = (logic_res == 8'h00);
                z_upd = 1'b1;
            end
            default: res = f_val;
        endcase
    end
endmodule

// ### csf_status_top.v
`include "csf_regs.vh"

// Core status flags register with APB access and event interrupts
module csf_status_top (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Instruction datapath
    input wire dp_valid,
    input wire [3:0] dp_op,
    input wire dp_dest_status,
    input wire [7:0] dp_f,
    input wire [7:0] dp_w,
    input wire [2:0] dp_bit,
    input wire [7:0] dp_logic_res,
    // Reset and power control events
    input wire wdt_timeout,
    input wire rst_cause_valid,
    input wire rst_cause_pin_wake,
    // Status outputs
    output reg [7:0] status_out,
    output reg page_preselect,
    output reg irq
);
    reg [7:0] status_q; // Status register
    reg [7:0] status_d; // Next status value
    reg [`CSF_EV_W-1:0] irq_stat_q; // Sticky event bits
    reg [`CSF_EV_W-1:0] irq_stat_d; // Next event bits
    reg [`CSF_EV_W-1:0] irq_en_q; // Event enables
    reg ready_q; // Wait state done
    reg [31:0] rdata_d; // Read mux
    reg addr_ok; // Address decodes to a register

    wire [7:0] alu_res; // Instruction result
    wire alu_z; // Zero flag value
    wire alu_dc; // Digit carry value
    wire alu_c; // Carry value
    wire upd_z; // Op affects Z
    wire upd_dcc; // Op affects Z, DC and C
    wire upd_c; // Op affects C alone

    wire [5:0] reg_idx; // Word index of the access
    wire acc_done; // Access phase completes now
    wire wr_done; // Write takes effect now
    wire dp_go; // Datapath instruction this cycle
    wire dp_arith; // Instruction touches any arithmetic flag
    wire op_kick; // Watchdog kick instruction
    wire op_sleep; // Sleep instruction
    wire sw_wr_status; // APB write to status
    wire [`CSF_EV_W-1:0] ev_vec; // Events this cycle
    wire [`CSF_EV_W-1:0] clr_vec; // Bits cleared by software

    // Flag arithmetic
    csf_flag_alu u_alu (
        .op(dp_op),
        .f_val(dp_f),
        .w_val(dp_w),
        .bit_sel(dp_bit),
        .logic_res(dp_logic_res),
        .c_in(status_q[`CSF_B_C]),
        .res(alu_res),
        .z_out(alu_z),
        .dc_out(alu_dc),
        .c_out(alu_c),
        .z_upd(upd_z),
        .dcc_upd(upd_dcc),
        .c_only_upd(upd_c)
    );

    // Bus decode; one wait state on every access
    assign reg_idx = paddr[7:2];
    assign acc_done = psel & penable & ready_q;
    assign wr_done = acc_done & pwrite & addr_ok;
    assign sw_wr_status = wr_done & (reg_idx == `CSF_IDX_STATUS);

    // Datapath decode
    assign dp_go = dp_valid;
    assign dp_arith = upd_z | upd_dcc | upd_c;
    assign op_kick = dp_go & (dp_op == `CSF_OP_KICK);
    assign op_sleep = dp_go & (dp_op == `CSF_OP_SLEEP);

    // Address decode for mapped words
    always @* begin
        case (reg_idx)
            `CSF_IDX_STATUS: addr_ok = 1'b1;
            `CSF_IDX_IRQ_STAT: addr_ok = 1'b1;
            `CSF_IDX_IRQ_EN: addr_ok = 1'b1;
            `CSF_IDX_IRQ_CLR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Read data; clear register reads as zero
    always @* begin
        case (reg_idx)
            `CSF_IDX_STATUS: rdata_d = {24'h000000, status_q};
            `CSF_IDX_IRQ_STAT: rdata_d = {27'h0000000, irq_stat_q};
            `CSF_IDX_IRQ_EN: rdata_d = {27'h0000000, irq_en_q};
            default: rdata_d = 32'h00000000;
        endcase
    end

    // Next status value
    always @* begin
        status_d = status_q;
        // Software write acts like moving a value into the file
        if (sw_wr_status) begin
            status_d[`CSF_B_WAKE] = pwdata[`CSF_B_WAKE];
            status_d[`CSF_B_PAGE] = pwdata[`CSF_B_PAGE];
            status_d[`CSF_B_Z] = pwdata[`CSF_B_Z];
            status_d[`CSF_B_NIB] = pwdata[`CSF_B_NIB];
            status_d[`CSF_B_C] = pwdata[`CSF_B_C];
        end
        // Datapath instruction wins over a software write
        if (dp_go) begin
            if (dp_dest_status && (dp_op != `CSF_OP_KICK)
                && (dp_op != `CSF_OP_SLEEP) && (dp_op != `CSF_OP_NOP)) begin
                // Result written into status like any file
                status_d[`CSF_B_WAKE] = alu_res[`CSF_B_WAKE];
                status_d[`CSF_B_PAGE] = alu_res[`CSF_B_PAGE];
                if (!dp_arith) begin
                    // Plain moves reach the flag bits too
                    status_d[`CSF_B_Z] = alu_res[`CSF_B_Z];
                    status_d[`CSF_B_NIB] = alu_res[`CSF_B_NIB];
                    status_d[`CSF_B_C] = alu_res[`CSF_B_C];
                end
                // Flag-affecting ops write none of the three flag bits
            end
            // Flags from the instruction replace written values
            if (upd_z || upd_dcc)
                status_d[`CSF_B_Z] = alu_z;
            if (upd_dcc)
                status_d[`CSF_B_NIB] = alu_dc;
            if (upd_dcc || upd_c)
                status_d[`CSF_B_C] = alu_c;
        end
        // Watchdog kick sets both reset-cause flags
        if (op_kick) begin
            status_d[`CSF_B_WDX] = 1'b1;
            status_d[`CSF_B_SLP] = 1'b1;
        end
        // Sleep sets the expiry flag and clears the sleep flag
        if (op_sleep) begin
            status_d[`CSF_B_WDX] = 1'b1;
            status_d[`CSF_B_SLP] = 1'b0;
        end
        // Watchdog time-out clears the expiry flag, last so it wins
        if (wdt_timeout)
            status_d[`CSF_B_WDX] = 1'b0;
        // Reset cause latched by power control
        if (rst_cause_valid)
            status_d[`CSF_B_WAKE] = rst_cause_pin_wake;
        // Reserved bit never stores anything
        status_d[`CSF_B_RSVD] = 1'b0;
    end

    // Events that set sticky interrupt bits
    assign ev_vec[`CSF_EV_TIMEOUT] = wdt_timeout;
    assign ev_vec[`CSF_EV_SLEEP] = op_sleep;
    assign ev_vec[`CSF_EV_KICK] = op_kick;
    assign ev_vec[`CSF_EV_WAKE] = rst_cause_valid & rst_cause_pin_wake;
    assign ev_vec[`CSF_EV_OVERRIDE] = dp_go & dp_dest_status & dp_arith;

    // Software clear mask, only on a completed write to the clear word
    assign clr_vec = (wr_done && (reg_idx == `CSF_IDX_IRQ_CLR))
        ? pwdata[`CSF_EV_W-1:0] : {`CSF_EV_W{1'b0}};

    // Set wins over a clear in the same cycle
    always @* begin
        irq_stat_d = (irq_stat_q & ~clr_vec) | ev_vec;
    end

    // Status register; expiry and sleep flags are never written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `CSF_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // Interrupt status and enable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= {`CSF_EV_W{1'b0}};
            irq_en_q <= {`CSF_EV_W{1'b0}};
        end else begin
            irq_stat_q <= irq_stat_d;
            // Enable word written in full
            if (wr_done && (reg_idx == `CSF_IDX_IRQ_EN))
                irq_en_q <= pwdata[`CSF_EV_W-1:0];
        end
    end

    // APB wait state and answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            // Raise ready one cycle into the access phase
            if (psel && penable && !ready_q) begin
                ready_q <= 1'b1;
                pready <= 1'b1;
                pslverr <= ~addr_ok;
                prdata <= (pwrite || !addr_ok) ? 32'h00000000 : rdata_d;
            end else begin
                // Drop after the completing edge
                ready_q <= 1'b0;
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h00000000;
            end
        end
    end

    // Registered outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out <= `CSF_STATUS_RST;
            page_preselect <= 1'b0;
            irq <= 1'b0;
        end else begin
            status_out <= status_d;
            page_preselect <= status_d[`CSF_B_PAGE];
            irq <= |(irq_stat_d & irq_en_q);
        end
    end
endmodule

// ### csf_dp_model.sv
// Instruction datapath stand-in: issues one instruction a cycle after go
module csf_dp_model (
    // Clock, reset and request
    input wire pclk, presetn, go, to_status,
    input wire [3:0] op,
    input wire [7:0] f, w, lres, status,
    input wire [2:0] bn,
    // Issued instruction
    output logic dp_valid, dp_dest_status,
    output logic [3:0] dp_op,
    output logic [7:0] dp_f, dp_w, dp_logic_res,
    output logic [2:0] dp_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle file, W and logic-result operands toggle so a stale value is never mistaken for a live one
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dp_valid, dp_dest_status, dp_op, dp_bit} <= 9'h000;
            {dp_f, dp_w, dp_logic_res} <= 24'h000000;
        end else begin
            dp_valid <= go;
            dp_dest_status <= to_status;
            dp_op <= op;
            dp_bit <= bn;
            dp_w <= go ? w : ~dp_w;
            dp_logic_res <= go ? lres : ~dp_logic_res;
            // Live status as operand, reserved bit never used
            dp_f <= !go ? ~dp_f : to_status ? status & 8'hbf : f;
        end
    end
endmodule

// ### csf_status_chk.sv
`include "csf_regs.vh"
// Port-level checks of the status flags block
module csf_status_chk (
    // Clock, reset, bus, datapath, events, outputs
    input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire [7:0] paddr, dp_f, dp_w, dp_logic_res, status_out,
    input wire [31:0] pwdata, prdata,
    input wire dp_valid, dp_dest_status, wdt_timeout, rst_cause_valid,
    input wire [3:0] dp_op,
    input wire [2:0] dp_bit,
    input wire rst_cause_pin_wake, page_preselect, irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Flags expected from the operands
    wire [8:0] sum = dp_f + dp_w;
    wire [4:0] nsum = dp_f[3:0] + dp_w[3:0];
    wire [2:0] add_fl = {sum[7:0] == 8'h00, nsum[4], sum[8]};
    wire [2:0] sub_fl = {dp_f == dp_w, dp_f[3:0] >= dp_w[3:0], dp_f >= dp_w};
    wire rot_c = (dp_op == `CSF_OP_ROL) ? dp_f[7] : dp_f[0];
    wire ev = wdt_timeout | rst_cause_valid;
    wire ex = dp_valid & !dp_dest_status & !ev;
    wire bus_wr = psel & penable & pready & pwrite;
    a_apb_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("pready not after one wait");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rsvd_zero: assert property (status_out[6] == 1'b0) else $error("bit 6 set");
    a_page_bit: assert property (page_preselect == status_out[5]) else $error("page");
    a_sleep_flags: assert property (dp_valid && dp_op == `CSF_OP_SLEEP && !ev
        |=> status_out[4:3] == 2'b10) else $error("sleep flags");
    a_kick_flags: assert property (dp_valid && dp_op == `CSF_OP_KICK && !ev
        |=> status_out[4:3] == 2'b11) else $error("kick flags");
    a_tout_clear: assert property (wdt_timeout |=> !status_out[4]) else $error("timeout");
    a_wake_cause: assert property (rst_cause_valid |=> status_out[7] == $past(rst_cause_pin_wake))
        else $error("wake cause");
    a_add_flags: assert property (ex && dp_op == `CSF_OP_ADD
        |=> status_out[2:0] == $past(add_fl)) else $error("add flags");
    a_sub_flags: assert property (ex && dp_op == `CSF_OP_SUB
        |=> status_out[2:0] == $past(sub_fl)) else $error("sub flags");
    a_rot_carry: assert property (ex && (dp_op == `CSF_OP_ROR || dp_op == `CSF_OP_ROL)
        |=> status_out[0] == $past(rot_c)) else $error("rotate carry");
    a_clear_stat: assert property (dp_valid && dp_dest_status && dp_op == `CSF_OP_CLR && !ev
        |=> status_out[7:2] == {3'h0, $past(status_out[4:3]), 1'b1} && $stable(status_out[1:0]))
        else $error("clear status");
    a_move_keep: assert property (ex && !bus_wr && dp_op inside {4'h1, 4'h2, 4'h3}
        |=> $stable(status_out[2:0])) else $error("flags moved");
    // Main scenarios reached
    c_add: cover property (ex && dp_op == `CSF_OP_ADD);
    c_wake: cover property (rst_cause_valid && rst_cause_pin_wake);
    c_err: cover property (pslverr);
    c_irq: cover property (irq);
endmodule
bind csf_status_top csf_status_chk chk (.*);

// ### csf_status_top_bench.sv
// Self-checking bench for the status flags block
module csf_status_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, go, to_status, err;
    logic wdt_timeout, rst_cause_valid, rst_cause_pin_wake;
    logic [7:0] paddr, f, w, lr;
    logic [31:0] pwdata, rd;
    logic [3:0] op;
    logic [2:0] bn;
    wire [31:0] prdata;
    wire pready, pslverr, dp_valid, dp_dest_status, page_preselect, irq;
    wire [3:0] dp_op;
    wire [7:0] dp_f, dp_w, dp_logic_res, status_out;
    wire [2:0] dp_bit;
    int n_mismatch = 0;
    int cmp_count = 0;
    csf_status_top dut (.*);
    csf_dp_model dpm (.pclk, .presetn, .go, .to_status, .op, .f, .w, .lres(lr),
        .status(status_out), .bn, .dp_valid, .dp_dest_status, .dp_op, .dp_f, .dp_w,
        .dp_logic_res, .dp_bit);
    // Flag table: op, file (also logic result), W, expected zero, nibble, carry
    logic [3:0] t_op[12] = '{4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h6, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9};
    logic [7:0] t_f[12] = '{8'h0f, 8'hff, 8'h80, 8'h05, 8'h03, 8'h10, 8'h07, 8'h02, 8'h80, 8'h7f,
        8'h00, 8'h05};
    logic [7:0] t_w[12] = '{8'h01, 8'h01, 8'h80, 8'h03, 8'h05, 8'h01, 8'h07, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00};
    logic [2:0] t_e[12] = '{3'h2, 3'h7, 3'h5, 3'h3, 3'h0, 3'h1, 3'h7, 3'h6, 3'h7, 3'h6, 3'h6, 3'h2};
    // Clock
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // APB transfer; read data and error taken at the pready edge
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int t;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1;
        t = 0;
        do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
        chk("pready", 1, pready);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // One instruction; status settled on return
    task automatic dp(logic [3:0] o, logic d, logic [7:0] fv, wv, logic [2:0] b);
        @(posedge pclk);
        {go, op, to_status, f, w, lr, bn} <= {1'b1, o, d, fv, wv, fv, b};
        @(posedge pclk);
        go <= 0;
        repeat (2) @(posedge pclk);
    endtask
    // One-cycle reset and power event
    task automatic pulse(logic t, logic v, logic p);
        @(posedge pclk);
        {wdt_timeout, rst_cause_valid, rst_cause_pin_wake} <= {t, v, p};
        @(posedge pclk);
        {wdt_timeout, rst_cause_valid} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic t_reset;
        chk("status", 8'h18, status_out);
        chk("irq", 0, irq);
        apb(0, 8'h0c, 0);
        chk("status read", 32'h18, rd);
        $display("Test reset done");
    endtask
    task automatic t_bus;
        apb(1, 8'h0c, 32'hff);
        apb(0, 8'h0c, 0);
        chk("status read", 32'hbf, rd);
        chk("page", 1, page_preselect);
        apb(1, 8'h0c, 32'h00);
        apb(0, 8'h0c, 0);
        chk("status read", 32'h18, rd);
        apb(0, 8'h3c, 0);
        chk("slverr", 1, err);
        chk("unmapped read", 0, rd);
        $display("Test bus done");
    endtask
    task automatic t_flags;
        for (int i = 0; i < 12; i++) begin
            dp(t_op[i], 0, t_f[i], t_w[i], 0);
            chk("flags", t_e[i], status_out[2:0]);
        end
        $display("Test flags done");
    endtask
    task automatic t_dest;
        dp(4'h1, 1, 8'h00, 8'h27, 0);
        chk("status", 8'h3f, status_out);
        chk("page", 1, page_preselect);
        dp(4'h4, 1, 8'h00, 8'h00, 0);
        chk("status", 8'h1f, status_out);
        dp(4'h5, 1, 8'h00, 8'h01, 0);
        chk("status", 8'h3a, status_out);
        dp(4'h2, 1, 8'h00, 8'h00, 3'h5);
        chk("status", 8'h1a, status_out);
        dp(4'h3, 1, 8'h00, 8'h00, 3'h0);
        chk("status", 8'h1b, status_out);
        $display("Test destination done");
    endtask
    task automatic t_events;
        apb(1, 8'h18, 32'h1f);
        apb(1, 8'h14, 32'h02);
        dp(4'hb, 0, 8'h00, 8'h00, 0);
        chk("sleep flags", 2'b10, status_out[4:3]);
        chk("irq", 1, irq);
        apb(1, 8'h14, 32'h00);
        apb(0, 8'h10, 0);
        chk("irq status", 32'h02, rd);
        chk("irq masked", 0, irq);
        apb(1, 8'h18, 32'h02);
        apb(1, 8'h14, 32'h02);
        apb(0, 8'h10, 0);
        chk("irq status", 32'h00, rd);
        chk("irq cleared", 0, irq);
        dp(4'ha, 0, 8'h00, 8'h00, 0);
        chk("kick flags", 2'b11, status_out[4:3]);
        pulse(1, 0, 0);
        chk("timeout flag", 0, status_out[4]);
        pulse(0, 1, 1);
        chk("wake flag", 1, status_out[7]);
        pulse(0, 1, 0);
        chk("wake flag", 0, status_out[7]);
        apb(0, 8'h10, 0);
        chk("irq status", 32'h0d, rd);
        $display("Test events done");
    endtask
    // Watchdog
    initial begin
        #20000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, go, to_status} = 6'h00;
        {wdt_timeout, rst_cause_valid, rst_cause_pin_wake} = 3'h0;
        {paddr, f, w, lr, pwdata, op, bn} = 71'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset;
        t_bus;
        t_flags;
        t_dest;
        t_events;
        finish_test;
    end
endmodule
